// [hdl/pfmd_top.sv]
/*
  Paper feed motor drive logic: DC lift/fence command decode, feed motor
  gating, transport and registration stepping phase outputs, APB slave.
  Assumes MCLK domain inputs; reference clocks are sampled levels.
*/
// What this block does
// - Drawer lift command both low floats both outputs, motor off.
// - Drawer lift: LH forward low/high, HL reverse high/low, HH brake low/low.
// - Bulk lift or fence command both low floats both outputs.
// - Bulk/fence: LH reverse low/high, HL forward high/low, HH brake low/low.
// - Feed motor runs only while its active-low on control is low.
// - Enabled feed motor speed follows reference clock frequency.
// - Transport four phase outputs derive from the step reference clock.
// - Transport phases emitted only while active-low enable low; else stopped.
// - Transport mode low ramps, high constant speed.
// - Registration four phase signals become four winding pulse outputs.
// - Registration speed from phase timing; mode low ramping, high constant.
`include "pfmd_defs.svh"
`timescale 1ns/100ps

module pfmd_top (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [31:0] PRDATA,
  input  wire logic        FEED_SPEED_REF_CLK,
  input  wire logic        TRANSPORT_STEP_REF_CLK,
  output logic      [1:0]  UPPER_LIFT_DRIVE_OUT,
  output logic      [1:0]  UPPER_LIFT_DRIVE_OE,
  output logic      [1:0]  LOWER_LIFT_DRIVE_OUT,
  output logic      [1:0]  LOWER_LIFT_DRIVE_OE,
  output logic      [1:0]  BULK_LIFT_DRIVE_OUT,
  output logic      [1:0]  BULK_LIFT_DRIVE_OE,
  output logic      [1:0]  FENCE_MOTOR_DRIVE_OUT,
  output logic      [1:0]  FENCE_MOTOR_DRIVE_OE,
  output logic             FEED_MOTOR_DRIVE,
  output logic             TRANSPORT_PHASE_A,
  output logic             TRANSPORT_PHASE_B,
  output logic             TRANSPORT_PHASE_A_BAR,
  output logic             TRANSPORT_PHASE_B_BAR,
  output logic             TRANSPORT_CONST_SPEED,
  output logic      [3:0]  REGIST_PULSE_OUT,
  output logic             REGIST_CONST_SPEED
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Drawer lift: {a,b}=01 forward out 01, 10 reverse out 10, 11 brake 00
  function automatic pfmd_pkg::pfmd_dc_drive_type pfmd_decode(input logic [1:0] cmd);
    pfmd_pkg::pfmd_dc_drive_type d;
    d.oe    = cmd[1] | cmd[0];
    d.out_a = cmd[1] & ~cmd[0];
    d.out_b = cmd[0] & ~cmd[1];
    return d;
  endfunction : pfmd_decode

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0]  lift_cmd_reg;
  logic        feed_motor_on_n_reg;
  logic [2:0]  xport_ctl_reg;
  logic [4:0]  regist_ctl_reg;
  logic [31:0] prdata_reg;
  logic        step_ref_d_reg;
  logic        feed_out_reg;
  pfmd_pkg::pfmd_phase_state_type xport_state_reg;
  pfmd_pkg::pfmd_phase_state_type xport_state_next;

  wire         apb_setup  = PSEL & ~PENABLE;
  wire         apb_access = PSEL & PENABLE;
  wire         apb_wr     = apb_access & PWRITE;
  wire         apb_rd     = PSEL & ~PENABLE & ~PWRITE;
  wire         sel_lift   = (PADDR == `PFMD_OFF_LIFT);
  wire         sel_feed   = (PADDR == `PFMD_OFF_FEED);
  wire         sel_xport  = (PADDR == `PFMD_OFF_XPORT);
  wire         sel_regist = (PADDR == `PFMD_OFF_REGIST);
  wire         sel_status = (PADDR == `PFMD_OFF_STATUS);
  wire         addr_hit   = sel_lift | sel_feed | sel_xport | sel_regist | sel_status;

  wire         xport_en   = ~xport_ctl_reg[`PFMD_XPORT_EN_N];
  wire         step_rise  = TRANSPORT_STEP_REF_CLK & ~step_ref_d_reg;
  wire  [3:0]  xport_bits = xport_state_reg;

  wire  [31:0] status_word = {23'h000000, feed_out_reg, xport_bits, xport_en,
                              2'h0, ~feed_motor_on_n_reg};
  wire  [31:0] rd_mux =
      sel_lift   ? {24'h000000, lift_cmd_reg} :
      sel_feed   ? {31'h00000000, feed_motor_on_n_reg} :
      sel_xport  ? {29'h00000000, xport_ctl_reg} :
      sel_regist ? {27'h0000000, regist_ctl_reg} :
      sel_status ? status_word : 32'h00000000;

  // One wait-free slave: ready in access phase, error on unmapped address
  assign PREADY  = apb_access;
  assign PSLVERR = apb_access & ~addr_hit;
  assign PRDATA  = prdata_reg;

  // ==========================================================
  // Register file
  // ==========================================================
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lift_cmd_reg        <= `PFMD_RST_LIFT;
      feed_motor_on_n_reg <= `PFMD_RST_FEED;
      xport_ctl_reg       <= `PFMD_RST_XPORT;
      regist_ctl_reg      <= `PFMD_RST_REGIST;
      prdata_reg          <= 32'h00000000;
    end else begin
      if (apb_wr && sel_lift)   lift_cmd_reg        <= PWDATA[7:0];
      if (apb_wr && sel_feed)   feed_motor_on_n_reg <= PWDATA[`PFMD_FEED_ON_N];
      if (apb_wr && sel_xport)  xport_ctl_reg       <= PWDATA[2:0];
      if (apb_wr && sel_regist) regist_ctl_reg      <= PWDATA[4:0];
      if (apb_rd)               prdata_reg          <= rd_mux;
      if (apb_setup && PWRITE)  prdata_reg          <= 32'h00000000;
    end
  end

  // ==========================================================
  // DC motor decode
  // ==========================================================
  pfmd_pkg::pfmd_dc_drive_type upper_d, lower_d, bulk_d, fence_d;
  assign upper_d = pfmd_decode(lift_cmd_reg[`PFMD_LIFT_UPPER+:2]);
  assign lower_d = pfmd_decode(lift_cmd_reg[`PFMD_LIFT_LOWER+:2]);
  assign bulk_d  = pfmd_decode(lift_cmd_reg[`PFMD_LIFT_BULK+:2]);
  assign fence_d = pfmd_decode(lift_cmd_reg[`PFMD_LIFT_FENCE+:2]);

  // Direction naming differs per motor family; electrical levels match
  assign UPPER_LIFT_DRIVE_OUT  = {upper_d.out_a, upper_d.out_b};
  assign UPPER_LIFT_DRIVE_OE   = {2{upper_d.oe}};
  assign LOWER_LIFT_DRIVE_OUT  = {lower_d.out_a, lower_d.out_b};
  assign LOWER_LIFT_DRIVE_OE   = {2{lower_d.oe}};
  assign BULK_LIFT_DRIVE_OUT   = {bulk_d.out_a, bulk_d.out_b};
  assign BULK_LIFT_DRIVE_OE    = {2{bulk_d.oe}};
  assign FENCE_MOTOR_DRIVE_OUT = {fence_d.out_a, fence_d.out_b};
  assign FENCE_MOTOR_DRIVE_OE  = {2{fence_d.oe}};

  // ==========================================================
  // Feed motor
  // ==========================================================
  // Drive follows the reference clock level, so speed tracks its frequency
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) feed_out_reg <= 1'b0;
    else        feed_out_reg <= ~feed_motor_on_n_reg & FEED_SPEED_REF_CLK;
  end
  assign FEED_MOTOR_DRIVE = feed_out_reg;

  // ==========================================================
  // Transport stepper
  // ==========================================================
  always_comb begin
    xport_state_next = xport_state_reg;
    if (xport_en && step_rise) begin
      case (xport_state_reg)
        pfmd_pkg::PFMD_PH_0: xport_state_next = pfmd_pkg::PFMD_PH_1;
        pfmd_pkg::PFMD_PH_1: xport_state_next = pfmd_pkg::PFMD_PH_2;
        pfmd_pkg::PFMD_PH_2: xport_state_next = pfmd_pkg::PFMD_PH_3;
        pfmd_pkg::PFMD_PH_3: xport_state_next = pfmd_pkg::PFMD_PH_0;
        default:             xport_state_next = pfmd_pkg::PFMD_PH_0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      step_ref_d_reg  <= 1'b0;
      xport_state_reg <= pfmd_pkg::PFMD_PH_0;
    end else begin
      step_ref_d_reg  <= TRANSPORT_STEP_REF_CLK;
      xport_state_reg <= xport_state_next;
    end
  end

  // Two-phase-on pattern from the one-hot step index, all low when disabled
  pfmd_pkg::pfmd_step_phase_type xport_ph;
  assign xport_ph.phase_a     = xport_en & (xport_bits[0] | xport_bits[1]);
  assign xport_ph.phase_b     = xport_en & (xport_bits[1] | xport_bits[2]);
  assign xport_ph.phase_a_bar = xport_en & (xport_bits[2] | xport_bits[3]);
  assign xport_ph.phase_b_bar = xport_en & (xport_bits[3] | xport_bits[0]);
  assign TRANSPORT_PHASE_A     = xport_ph.phase_a;
  assign TRANSPORT_PHASE_B     = xport_ph.phase_b;
  assign TRANSPORT_PHASE_A_BAR = xport_ph.phase_a_bar;
  assign TRANSPORT_PHASE_B_BAR = xport_ph.phase_b_bar;
  assign TRANSPORT_CONST_SPEED = xport_en & xport_ctl_reg[`PFMD_XPORT_MODE];

  // ==========================================================
  // Registration stepper
  // ==========================================================
  // Software writes each phase step; its write timing sets the speed
  assign REGIST_PULSE_OUT   = regist_ctl_reg[`PFMD_REG_PHASE+:4];
  assign REGIST_CONST_SPEED = regist_ctl_reg[`PFMD_REG_MODE];

  // ==========================================================
  // Checks
  // ==========================================================
  // Drawer lifts: command {a,b} per pair, one check per code
  a_upper_off_float: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[1:0] == 2'h0 |-> UPPER_LIFT_DRIVE_OE == 2'h0)
    else $error("upper lift not floated");

  a_lower_off_float: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[3:2] == 2'h0 |-> LOWER_LIFT_DRIVE_OE == 2'h0)
    else $error("lower lift not floated");

  a_upper_fwd_lh: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[1:0] == 2'h1 |-> UPPER_LIFT_DRIVE_OUT == 2'h1 && UPPER_LIFT_DRIVE_OE == 2'h3)
    else $error("upper lift forward wrong");

  a_upper_rev_hl: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[1:0] == 2'h2 |-> UPPER_LIFT_DRIVE_OUT == 2'h2 && UPPER_LIFT_DRIVE_OE == 2'h3)
    else $error("upper lift reverse wrong");

  a_upper_brake: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[1:0] == 2'h3 |-> UPPER_LIFT_DRIVE_OUT == 2'h0 && UPPER_LIFT_DRIVE_OE == 2'h3)
    else $error("upper lift brake wrong");

  a_lower_fwd_lh: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[3:2] == 2'h1 |-> LOWER_LIFT_DRIVE_OUT == 2'h1 && LOWER_LIFT_DRIVE_OE == 2'h3)
    else $error("lower lift forward wrong");

  a_lower_rev_hl: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[3:2] == 2'h2 |-> LOWER_LIFT_DRIVE_OUT == 2'h2 && LOWER_LIFT_DRIVE_OE == 2'h3)
    else $error("lower lift reverse wrong");

  a_lower_brake: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[3:2] == 2'h3 |-> LOWER_LIFT_DRIVE_OUT == 2'h0 && LOWER_LIFT_DRIVE_OE == 2'h3)
    else $error("lower lift brake wrong");

  // Bulk lift and fence: same levels, opposite direction naming
  a_bulk_off_float: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[5:4] == 2'h0 |-> BULK_LIFT_DRIVE_OE == 2'h0)
    else $error("bulk lift not floated");

  a_fence_off_float: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[7:6] == 2'h0 |-> FENCE_MOTOR_DRIVE_OE == 2'h0)
    else $error("fence not floated");

  a_bulk_rev_lh: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[5:4] == 2'h1 |-> BULK_LIFT_DRIVE_OUT == 2'h1 && BULK_LIFT_DRIVE_OE == 2'h3)
    else $error("bulk lift reverse wrong");

  a_bulk_fwd_hl: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[5:4] == 2'h2 |-> BULK_LIFT_DRIVE_OUT == 2'h2 && BULK_LIFT_DRIVE_OE == 2'h3)
    else $error("bulk lift forward wrong");

  a_bulk_brake: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[5:4] == 2'h3 |-> BULK_LIFT_DRIVE_OUT == 2'h0 && BULK_LIFT_DRIVE_OE == 2'h3)
    else $error("bulk lift brake wrong");

  a_fence_rev_lh: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[7:6] == 2'h1 |-> FENCE_MOTOR_DRIVE_OUT == 2'h1 && FENCE_MOTOR_DRIVE_OE == 2'h3)
    else $error("fence reverse wrong");

  a_fence_fwd_hl: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[7:6] == 2'h2 |-> FENCE_MOTOR_DRIVE_OUT == 2'h2 && FENCE_MOTOR_DRIVE_OE == 2'h3)
    else $error("fence forward wrong");

  a_fence_brake: assert property (@(posedge MCLK) disable iff (!RST_N)
    lift_cmd_reg[7:6] == 2'h3 |-> FENCE_MOTOR_DRIVE_OUT == 2'h0 && FENCE_MOTOR_DRIVE_OE == 2'h3)
    else $error("fence brake wrong");

  // Feed drive is registered, so it answers the previous cycle's inputs
  a_feed_off_stop: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(feed_motor_on_n_reg) |-> !FEED_MOTOR_DRIVE)
    else $error("feed motor driven while off");

  a_feed_tracks_ref: assert property (@(posedge MCLK) disable iff (!RST_N)
    !$past(feed_motor_on_n_reg) |-> FEED_MOTOR_DRIVE == $past(FEED_SPEED_REF_CLK))
    else $error("feed drive not tracking reference");

  // Transport: one step per detected reference edge, frozen otherwise
  a_xport_step_adv: assert property (@(posedge MCLK) disable iff (!RST_N)
    xport_en && step_rise |=>
      xport_bits == {$past(xport_bits[2:0]), $past(xport_bits[3])})
    else $error("transport phase not advanced");

  a_xport_hold_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
    !step_rise |=> $stable(xport_bits))
    else $error("transport stepped without reference edge");

  a_xport_disabled: assert property (@(posedge MCLK) disable iff (!RST_N)
    !xport_en |-> {TRANSPORT_PHASE_A, TRANSPORT_PHASE_B, TRANSPORT_PHASE_A_BAR,
                   TRANSPORT_PHASE_B_BAR} == 4'h0)
    else $error("transport phases driven while disabled");

  a_xport_frozen: assert property (@(posedge MCLK) disable iff (!RST_N)
    !xport_en |=> $stable(xport_bits))
    else $error("transport moving while disabled");

  a_xport_const_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    !xport_en |-> !TRANSPORT_CONST_SPEED)
    else $error("transport mode driven while disabled");

  a_xport_mode_sel: assert property (@(posedge MCLK) disable iff (!RST_N)
    xport_en |-> TRANSPORT_CONST_SPEED == xport_ctl_reg[`PFMD_XPORT_MODE])
    else $error("transport mode wrong");

  a_regist_phase_out: assert property (@(posedge MCLK) disable iff (!RST_N)
    apb_wr && sel_regist |=> REGIST_PULSE_OUT == $past(PWDATA[3:0]))
    else $error("registration phase not driven");

  a_regist_mode_out: assert property (@(posedge MCLK) disable iff (!RST_N)
    apb_wr && sel_regist |=> REGIST_CONST_SPEED == $past(PWDATA[4]))
    else $error("registration mode not driven");

endmodule : pfmd_top

// [hdl/pfmd_defs.svh]
/*
  Constants for the paper feed motor drive logic: register offsets, field
  positions, reset values. Assumes inclusion by bare name only.
*/
`ifndef PFMD_DEFS_SVH
`define PFMD_DEFS_SVH

`define PFMD_OFF_LIFT     12'h000
`define PFMD_OFF_FEED     12'h004
`define PFMD_OFF_XPORT    12'h008
`define PFMD_OFF_REGIST   12'h00C
`define PFMD_OFF_STATUS   12'h010

`define PFMD_LIFT_UPPER   0
`define PFMD_LIFT_LOWER   2
`define PFMD_LIFT_BULK    4
`define PFMD_LIFT_FENCE   6
`define PFMD_FEED_ON_N    0
`define PFMD_XPORT_EN_N   0
`define PFMD_XPORT_MODE   1
`define PFMD_XPORT_DIR    2
`define PFMD_REG_PHASE    0
`define PFMD_REG_MODE     4

`define PFMD_RST_LIFT     8'h00
`define PFMD_RST_FEED     1'h1
`define PFMD_RST_XPORT    3'h1
`define PFMD_RST_REGIST   5'h00

`endif

// [hdl/pfmd_pkg.sv]
/*
  Types for the paper feed motor drive logic.
  Assumes pfmd_defs.svh for numeric constants.
*/
package pfmd_pkg;

  // Two leg levels plus one shared enable toward one DC motor driver leg pair
  typedef struct packed {
    logic out_a;
    logic out_b;
    logic oe;
  } pfmd_dc_drive_type;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic phase_a_bar;
    logic phase_b_bar;
  } pfmd_step_phase_type;

  typedef enum logic [3:0] {
    PFMD_PH_0 = 4'b0001,
    PFMD_PH_1 = 4'b0010,
    PFMD_PH_2 = 4'b0100,
    PFMD_PH_3 = 4'b1000
  } pfmd_phase_state_type;

endpackage : pfmd_pkg

// [test/pfmd_motor_model.sv]
/* Driver stage and DC motor model: turns the drive legs into a motor state.
   Assumes legs are levels and that OE is high on both legs while driven. */
`timescale 1ns/100ps
// ==========================================
// Motor state from the two driven legs
module pfmd_motor_model (
  input  wire logic [1:0] drive_out,
  input  wire logic [1:0] drive_oe,
  input  wire logic       bulk_family,
  output logic      [1:0] motor_state
);
  // 0 off, 1 clockwise, 2 counter-clockwise, 3 brake
  // The two families turn opposite ways for the same leg levels
  always_comb begin
    if (drive_oe !== 2'h3) motor_state = 2'h0;
    else if (drive_out === 2'h1) motor_state = bulk_family ? 2'h2 : 2'h1;
    else if (drive_out === 2'h2) motor_state = bulk_family ? 2'h1 : 2'h2;
    else if (drive_out === 2'h0) motor_state = 2'h3;
    else motor_state = 2'h0;
  end
endmodule : pfmd_motor_model

// [test/pfmd_top_test.sv]
/* Self-checking bench for the paper feed motor drive logic.
   Assumes a zero-wait APB slave and MCLK-sampled reference clocks. */
`include "pfmd_defs.svh"
`timescale 1ns/100ps
module pfmd_top_test;
  logic        mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        err, feed_ref = 1'h0, step_ref = 1'h0;
  wire         pready, pslverr, feed_drv, ph_a, ph_b, ph_ab, ph_bb, x_const, r_const;
  wire  [31:0] prdata;
  wire  [1:0]  up_out, up_oe, lo_out, lo_oe, bu_out, bu_oe, fe_out, fe_oe, up_st, bu_st;
  wire  [3:0]  r_pulse;
  int          error_cnt = 0, check_count = 0, cycles = 0;

  pfmd_top uut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
    .FEED_SPEED_REF_CLK(feed_ref), .TRANSPORT_STEP_REF_CLK(step_ref),
    .UPPER_LIFT_DRIVE_OUT(up_out), .UPPER_LIFT_DRIVE_OE(up_oe), .LOWER_LIFT_DRIVE_OUT(lo_out),
    .LOWER_LIFT_DRIVE_OE(lo_oe), .BULK_LIFT_DRIVE_OUT(bu_out), .BULK_LIFT_DRIVE_OE(bu_oe),
    .FENCE_MOTOR_DRIVE_OUT(fe_out), .FENCE_MOTOR_DRIVE_OE(fe_oe), .FEED_MOTOR_DRIVE(feed_drv),
    .TRANSPORT_PHASE_A(ph_a), .TRANSPORT_PHASE_B(ph_b), .TRANSPORT_PHASE_A_BAR(ph_ab),
    .TRANSPORT_PHASE_B_BAR(ph_bb), .TRANSPORT_CONST_SPEED(x_const),
    .REGIST_PULSE_OUT(r_pulse), .REGIST_CONST_SPEED(r_const));
  pfmd_motor_model upper_motor (.drive_out(up_out), .drive_oe(up_oe), .bulk_family(1'h0),
    .motor_state(up_st));
  pfmd_motor_model bulk_motor (.drive_out(bu_out), .drive_oe(bu_oe), .bulk_family(1'h1),
    .motor_state(bu_st));

  always #12.5 mclk = ~mclk;

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= addr; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask : apb

  task automatic step_pulse;
    step_ref <= 1'h1; repeat (4) @(posedge mclk);
    step_ref <= 1'h0; repeat (4) @(posedge mclk);
  endtask : step_pulse

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================
  // Scenarios
  task automatic t_reset;
    apb(1'h0, `PFMD_OFF_LIFT, 32'h0); chk("lift reg", 32'h0, rd);
    apb(1'h0, `PFMD_OFF_FEED, 32'h0); chk("feed reg", 32'h1, rd);
    apb(1'h0, `PFMD_OFF_XPORT, 32'h0); chk("xport reg", 32'h1, rd);
    apb(1'h0, `PFMD_OFF_REGIST, 32'h0); chk("regist reg", 32'h0, rd);
    apb(1'h0, `PFMD_OFF_STATUS, 32'h0); chk("status reg", 32'h10, rd);
    chk("lift oe", 32'h0, {up_oe, lo_oe, bu_oe, fe_oe});
    chk("phases off", 32'h0, {ph_a, ph_b, ph_ab, ph_bb});
    apb(1'h0, 12'h020, 32'h0); chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_lift;
    for (int v = 0; v < 4; v++) begin
      logic [1:0] c;
      logic [1:0] e;
      c = v[1:0];
      e = (c == 2'h0) ? 2'h0 : 2'h3;
      apb(1'h1, `PFMD_OFF_LIFT, {24'h0, {4{c}}});
      @(posedge mclk);
      chk("lift oe", {24'h0, {4{e}}}, {up_oe, lo_oe, bu_oe, fe_oe});
      if (c != 2'h0) chk("lift legs", {24'h0, {4{(c == 2'h3) ? 2'h0 : c}}},
        {up_out, lo_out, bu_out, fe_out});
      chk("drawer state", c, up_st);
      chk("bulk state", (c == 2'h1) ? 2'h2 : (c == 2'h2) ? 2'h1 : c, bu_st);
    end
    $display("test lift done");
  endtask : t_lift

  task automatic t_feed;
    apb(1'h1, `PFMD_OFF_FEED, 32'h0);
    repeat (3) begin
      feed_ref <= 1'h1; repeat (3) @(posedge mclk);
      chk("feed drive high", 32'h1, feed_drv);
      feed_ref <= 1'h0; repeat (3) @(posedge mclk);
      chk("feed drive low", 32'h0, feed_drv);
    end
    apb(1'h1, `PFMD_OFF_FEED, 32'h1);
    feed_ref <= 1'h1; repeat (3) @(posedge mclk);
    chk("feed stopped", 32'h0, feed_drv);
    feed_ref <= 1'h0;
    $display("test feed done");
  endtask : t_feed

  task automatic t_xport;
    logic [3:0] p;
    apb(1'h1, `PFMD_OFF_XPORT, 32'h2);
    @(posedge mclk);
    chk("const speed", 32'h1, x_const);
    p = 4'h9;
    chk("first phase", p, {ph_a, ph_b, ph_ab, ph_bb});
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        apb(1'h1, `PFMD_OFF_XPORT, 32'h0);
        @(posedge mclk);
        chk("ramp mode", 32'h0, x_const);
      end
      step_pulse();
      p = {p[0], p[3:1]};
      chk("phase step", p, {ph_a, ph_b, ph_ab, ph_bb});
    end
    apb(1'h1, `PFMD_OFF_XPORT, 32'h3);
    step_pulse();
    chk("disabled phases", 32'h0, {ph_a, ph_b, ph_ab, ph_bb, x_const});
    $display("test transport done");
  endtask : t_xport

  task automatic t_regist;
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, `PFMD_OFF_REGIST, 32'h10 | (32'h1 << i));
      @(posedge mclk);
      chk("regist pulse", 32'h1 << i, r_pulse);
      chk("regist const", 32'h1, r_const);
    end
    apb(1'h1, `PFMD_OFF_REGIST, 32'h0);
    @(posedge mclk);
    chk("regist ramp", 32'h0, {r_pulse, r_const});
    $display("test registration done");
  endtask : t_regist

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset();
    t_lift();
    t_feed();
    t_xport();
    t_regist();
    print_verdict();
  end
endmodule : pfmd_top_test
